/* logic/nvm_pkg.sv */
package nvm_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int IDX_W = 22;
  localparam int PB_BYTES = 64;
  localparam int PB_WORDS = 16;
  localparam int PB_IDX_W = 4;
  localparam int WORD_LSB = 2;
  localparam int PAGE_LSB = 6;
  localparam int NUM_REGIONS = 16;
  localparam int RGN_W = 4;
  localparam int PAGE_NUMBER_FIELD_W = 16;
  localparam int CODE_W = 6;
  localparam int KEY_W = 8;
  localparam int WAIT_W = 3;

  // Fixed windows of the extra pages
  localparam logic [ADDR_W-1:0] USER_PAGE_BASE = 24'h80_0000;
  localparam logic [ADDR_W-1:0] FACTORY_PAGE_BASE = 24'h80_0200;
  localparam logic [ADDR_W-1:0] WORD_STEP = 24'h00_0004;

  // Wait counts on the high-speed bus
  localparam logic [WAIT_W-1:0] PB_WRITE_WAITS = 3'h4;
  localparam logic [WAIT_W-1:0] READ_1WS_WAITS = 3'h1;
  localparam logic [WAIT_W-1:0] WAIT_STEP = 3'h1;

  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFF_FFFF;

  // Command codes
  localparam logic [CODE_W-1:0] CMD_WRITE_PAGE = 6'h01;
  localparam logic [CODE_W-1:0] CMD_ERASE_PAGE = 6'h02;
  localparam logic [CODE_W-1:0] CMD_CLEAR_PB = 6'h03;
  localparam logic [CODE_W-1:0] CMD_ERASE_ALL = 6'h08;
  localparam logic [CODE_W-1:0] CMD_CHECK_PAGE = 6'h0C;
  localparam logic [CODE_W-1:0] CMD_WRITE_USER = 6'h0D;
  localparam logic [CODE_W-1:0] CMD_ERASE_USER = 6'h0E;
  localparam logic [CODE_W-1:0] CMD_FAST_ON = 6'h10;
  localparam logic [CODE_W-1:0] CMD_FAST_OFF = 6'h11;

  typedef enum logic [1:0] {
    CMD_IDLE = 2'h0,
    CMD_WAIT_IDLE = 2'h1,
    CMD_RUN = 2'h3
  } cmd_state_t;

  typedef struct packed {
    logic valid;
    logic seq;
    logic write;
    logic [ADDR_W-1:0] addr;
  } hs_req_t;

  typedef struct packed {
    logic [KEY_W-1:0] key;
    logic [PAGE_NUMBER_FIELD_W-1:0] page;
    logic [1:0] unused;
    logic [CODE_W-1:0] code;
  } cmd_word_t;

  typedef struct packed {
    logic command_done;
    logic fast_read_active;
    logic page_erase_check_result;
    logic prog_error;
    logic lock_error;
  } status_t;

  typedef struct packed {
    logic ready;
    logic [DATA_W-1:0] rdata;
    logic dwrite;
    logic [ADDR_W-1:0] daddr;
    logic [WAIT_W-1:0] wcnt;
    logic pf_valid;
    logic [ADDR_W-1:0] pf_addr;
    logic [DATA_W-1:0] pf_data;
    cmd_state_t cst;
    logic [CODE_W-1:0] code;
    logic [PAGE_NUMBER_FIELD_W-1:0] page_number_field;
    logic [IDX_W-1:0] cidx;
    logic [IDX_W-1:0] cend;
    logic qacc;
    status_t status;
  } ctrl_state_t;

  localparam status_t STATUS_RESET = 5'h10;
endpackage

/* logic/nvm_bank_array.sv */
`timescale 1ns/1ps
module nvm_bank_array
  import nvm_pkg::*;
#(
  parameter int ROWS = 544
) (
  // Clock
  input wire logic i_clk,
  // Read ports, one per bank
  input wire logic [1:0] i_rd_en,
  input wire logic [1:0][$clog2(ROWS)-1:0] i_rd_row,
  output logic [1:0][DATA_W-1:0] o_rd_data,
  // Shared program port
  input wire logic i_wr_en,
  input wire logic i_wr_bank,
  input wire logic [$clog2(ROWS)-1:0] i_wr_row,
  input wire logic [DATA_W-1:0] i_wr_data
);
  if (ROWS < 2) begin : g_bad_rows
    $error("nvm_bank_array: ROWS too small");
  end

  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic [DATA_W-1:0] mem [ROWS];

    always_ff @(posedge i_clk) begin
      if (i_wr_en && (i_wr_bank == 1'(b))) begin
        mem[i_wr_row] <= i_wr_data;
      end
    end

    // A disabled port returns zero and draws no read power
    assign o_rd_data[b] = (i_rd_en[b] && (i_rd_row[b] < ROWS)) ? mem[i_rd_row[b]] : '0;
  end
endmodule

/* logic/nvm_page_buffer.sv */
`timescale 1ns/1ps
module nvm_page_buffer
  import nvm_pkg::*;
#(
  parameter int WORDS = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Bus side, write only
  input wire logic i_clear,
  input wire logic i_wr_en,
  input wire logic [$clog2(WORDS)-1:0] i_wr_idx,
  input wire logic [DATA_W-1:0] i_wr_data,
  // Programming side
  input wire logic [$clog2(WORDS)-1:0] i_rd_idx,
  output logic [DATA_W-1:0] o_rd_data
);
  if (WORDS < 2) begin : g_bad_words
    $error("nvm_page_buffer: WORDS too small");
  end

  logic [DATA_W-1:0] mem [WORDS];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= ERASED_WORD;
      end
    end else if (i_clear) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= ERASED_WORD;
      end
    end else if (i_wr_en) begin
      mem[i_wr_idx] <= mem[i_wr_idx] & i_wr_data;
    end
  end

  assign o_rd_data = mem[i_rd_idx];
endmodule

/* logic/nvm_controller.sv */
// Function
// - two ports, high-speed bus for reads and buffer writes, command port
// - pages grouped into 16 equal regions, each locked by its own fuse
// - user page changed only by its own commands, survives chip erase
// - zero-wait mode returns one addressed 32-bit word per clock, stalls only while a command runs
// - one-wait mode stalls exactly one cycle on the first beat only
// - two 32-bit banks; zero-wait reads one, one-wait reads both on a fresh fetch
// - wait states come from a control input chosen by software
// - reads in reserved space return any value
// - user page at 0x800000, factory page at 0x800200, one page each
// - fast read mode set and cleared by commands, status shown, off at reset
// - page check ANDs all bits of the page into a status bit
// - bus write updates buffer word A mod 64 and page number A/64
// - page buffer has no read path for software
// - buffer write takes four wait states, other accesses stall meanwhile
// - buffer write ANDs new data into old contents
// - only the clear command and reset return buffer bits to one
// - buffer is not cleared after page write; software clears it
// - write page copies the whole buffer into a main page; write user copies it into the user page
// - a command runs only with the key in its top eight bits
// - flash reads stall while a command runs
`timescale 1ns/1ps
module nvm_controller
  import nvm_pkg::*;
#(
  parameter int NUM_PAGES = 64,
  // Key value is arbitrary
  parameter logic [KEY_W-1:0] CMD_KEY = 8'h5A
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // High-speed system bus
  input wire hs_req_t i_hs_req,
  input wire logic [DATA_W-1:0] i_hs_wdata,
  output logic o_hs_ready,
  output logic [DATA_W-1:0] o_hs_rdata,
  // Peripheral bus commands and configuration
  input wire logic i_cmd_write,
  input wire cmd_word_t i_cmd_word,
  input wire logic i_status_read,
  input wire logic i_wait_state_select,
  // Region lock fuses
  input wire logic [NUM_REGIONS-1:0] i_region_lock,
  // Status
  output status_t o_status,
  output logic [PAGE_NUMBER_FIELD_W-1:0] o_page_number
);
  localparam int MAIN_WORDS = NUM_PAGES * PB_WORDS;
  localparam int ROWS = (MAIN_WORDS + 2 * PB_WORDS) / 2;
  localparam int ROW_W = $clog2(ROWS);
  localparam int REGION_PAGES = NUM_PAGES / NUM_REGIONS;
  localparam logic [ADDR_W-1:0] MAIN_BYTES = ADDR_W'(MAIN_WORDS * 4);
  localparam logic [IDX_W-1:0] USER_IDX = IDX_W'(MAIN_WORDS);
  localparam logic [IDX_W-1:0] FACTORY_IDX = IDX_W'(MAIN_WORDS + PB_WORDS);
  localparam logic [IDX_W-1:0] PAGE_LAST = IDX_W'(PB_WORDS - 1);
  localparam logic [IDX_W-1:0] MAIN_LAST = IDX_W'(MAIN_WORDS - 1);

  if ((NUM_PAGES % NUM_REGIONS) != 0 || NUM_PAGES < NUM_REGIONS ||
      NUM_PAGES * PB_BYTES > int'(USER_PAGE_BASE) || NUM_PAGES > 2 ** PAGE_NUMBER_FIELD_W) begin : g_bad_pages
    $error("nvm_controller: NUM_PAGES not supported");
  end

  ctrl_state_t st_reg;
  ctrl_state_t st_next;

  logic [1:0] rd_en;
  logic [1:0][ROW_W-1:0] rd_row;
  logic [1:0][DATA_W-1:0] rd_data;
  logic [IDX_W-1:0] ridx;
  logic [DATA_W-1:0] word_lo;
  logic [DATA_W-1:0] word_hi;
  logic bk_we;
  logic [DATA_W-1:0] bk_wdata;
  logic pb_we;
  logic pb_clear;
  logic [DATA_W-1:0] pb_rdata;

  // fixed windows; reserved space maps to word zero
  function automatic logic [IDX_W-1:0] map_addr(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] w;
    w = IDX_W'(a[PB_IDX_W+WORD_LSB-1:WORD_LSB]);
    if (a < MAIN_BYTES) begin
      return a[ADDR_W-1:WORD_LSB];
    end else if (a[ADDR_W-1:PAGE_LSB] == USER_PAGE_BASE[ADDR_W-1:PAGE_LSB]) begin
      return USER_IDX + w;
    end else if (a[ADDR_W-1:PAGE_LSB] == FACTORY_PAGE_BASE[ADDR_W-1:PAGE_LSB]) begin
      return FACTORY_IDX + w;
    end
    return '0;
  endfunction

  // word ridx and its successor sit in opposite banks
  assign rd_row[0] = ROW_W'((ridx + IDX_W'(ridx[0])) >> 1);
  assign rd_row[1] = ROW_W'(ridx >> 1);
  assign word_lo = ridx[0] ? rd_data[1] : rd_data[0];
  assign word_hi = ridx[0] ? rd_data[0] : rd_data[1];

  nvm_bank_array #(
    .ROWS(ROWS)
  ) u_banks (
    .i_clk(i_clk),
    .i_rd_en(rd_en),
    .i_rd_row(rd_row),
    .o_rd_data(rd_data),
    .i_wr_en(bk_we),
    .i_wr_bank(st_reg.cidx[0]),
    .i_wr_row(ROW_W'(st_reg.cidx >> 1)),
    .i_wr_data(bk_wdata)
  );

  // buffer contents only reach the programming path
  nvm_page_buffer #(
    .WORDS(PB_WORDS)
  ) u_pbuf (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(pb_clear),
    .i_wr_en(pb_we),
    .i_wr_idx(st_reg.daddr[PB_IDX_W+WORD_LSB-1:WORD_LSB]),
    .i_wr_data(i_hs_wdata),
    .i_rd_idx(st_reg.cidx[PB_IDX_W-1:0]),
    .o_rd_data(pb_rdata)
  );

  always_comb begin
    logic busy;
    logic hit;
    logic do_read;
    logic one_wait;
    logic is_write;
    logic run_ok;
    logic [ADDR_W-1:0] acc_addr;
    logic [IDX_W-1:0] page_base;
    logic [RGN_W-1:0] region;
    logic [IDX_W-1:0] run_first;
    logic [IDX_W-1:0] run_last;
    busy = 1'b0;
    hit = 1'b0;
    do_read = 1'b0;
    is_write = 1'b0;
    run_ok = 1'b0;
    run_first = '0;
    run_last = '0;
    st_next = st_reg;
    rd_en = '0;
    bk_we = 1'b0;
    pb_we = 1'b0;
    pb_clear = 1'b0;
    one_wait = i_wait_state_select;
    busy = (st_reg.cst == CMD_RUN);
    // sequential beat already fetched from the other bank
    hit = st_reg.ready && i_hs_req.valid && !i_hs_req.write && i_hs_req.seq && one_wait &&
          st_reg.pf_valid && (i_hs_req.addr == st_reg.pf_addr);
    acc_addr = st_reg.ready ? i_hs_req.addr : st_reg.daddr;
    ridx = busy ? st_reg.cidx : map_addr(hit ? acc_addr + WORD_STEP : acc_addr);
    page_base = IDX_W'(st_reg.page_number_field) << PB_IDX_W;
    region = RGN_W'(st_reg.page_number_field / PAGE_NUMBER_FIELD_W'(REGION_PAGES));
    is_write = (st_reg.code == CMD_WRITE_PAGE) || (st_reg.code == CMD_WRITE_USER);
    bk_wdata = is_write ? pb_rdata : ERASED_WORD;

    if (i_status_read) begin
      st_next.status.prog_error = 1'b0;
      st_next.status.lock_error = 1'b0;
    end

    if (st_reg.ready) begin
      if (i_hs_req.valid) begin
        st_next.daddr = i_hs_req.addr;
        st_next.dwrite = i_hs_req.write;
        if (!i_hs_req.write && !busy && (!one_wait || hit)) begin
          do_read = 1'b1;
        end else begin
          st_next.ready = 1'b0;
          // four waits on buffer writes; one on a first beat
          if (i_hs_req.write) begin
            st_next.wcnt = PB_WRITE_WAITS - WAIT_STEP;
          end else if (one_wait) begin
            st_next.wcnt = READ_1WS_WAITS - WAIT_STEP;
          end else begin
            st_next.wcnt = '0;
          end
        end
      end
    end else if (st_reg.wcnt != '0) begin
      st_next.wcnt = st_reg.wcnt - WAIT_STEP;
    // hold the data phase until the command ends
    end else if (!busy) begin
      st_next.ready = 1'b1;
      if (st_reg.dwrite) begin
        // array untouched, buffer word and page number updated
        pb_we = 1'b1;
        st_next.page_number_field = PAGE_NUMBER_FIELD_W'(st_reg.daddr[ADDR_W-1:PAGE_LSB]);
        st_next.pf_valid = 1'b0;
      end else begin
        do_read = 1'b1;
      end
    end

    if (do_read) begin
      // one port in zero-wait, both on a fresh one-wait fetch
      rd_en[ridx[0]] = 1'b1;
      if (one_wait && !hit) begin
        rd_en = '1;
      end
      // user and factory pages read like any other word
      st_next.rdata = hit ? st_reg.pf_data : word_lo;
      st_next.pf_valid = one_wait;
      st_next.pf_addr = acc_addr + WORD_STEP;
      st_next.pf_data = hit ? word_lo : word_hi;
    end

    unique case (st_reg.cst)
      CMD_IDLE: begin
      end
      CMD_WAIT_IDLE: begin
        // Commands start only on an idle bus cycle
        if (st_reg.ready && !i_hs_req.valid) begin
          st_next.cst = CMD_IDLE;
          st_next.status.command_done = 1'b1;
          st_next.pf_valid = 1'b0;
          case (st_reg.code)
            // mode set and cleared by commands
            CMD_FAST_ON: st_next.status.fast_read_active = 1'b1;
            CMD_FAST_OFF: st_next.status.fast_read_active = 1'b0;
            CMD_CLEAR_PB: pb_clear = 1'b1;
            CMD_WRITE_PAGE, CMD_ERASE_PAGE, CMD_CHECK_PAGE: begin
              if (st_reg.page_number_field >= PAGE_NUMBER_FIELD_W'(NUM_PAGES)) begin
                st_next.status.prog_error = 1'b1;
              end else if (i_region_lock[region] && st_reg.code != CMD_CHECK_PAGE) begin
                st_next.status.lock_error = 1'b1;
              end else begin
                run_ok = 1'b1;
                run_first = page_base;
                run_last = page_base + PAGE_LAST;
              end
            end
            CMD_ERASE_ALL: begin
              if (|i_region_lock) begin
                st_next.status.lock_error = 1'b1;
              end else begin
                // chip erase stops short of the user page
                run_ok = 1'b1;
                run_first = '0;
                run_last = MAIN_LAST;
              end
            end
            // user page has its own commands
            CMD_WRITE_USER, CMD_ERASE_USER: begin
              run_ok = 1'b1;
              run_first = USER_IDX;
              run_last = USER_IDX + PAGE_LAST;
            end
            default: begin
            end
          endcase
          if (run_ok) begin
            st_next.cst = CMD_RUN;
            st_next.status.command_done = 1'b0;
            st_next.qacc = 1'b1;
            st_next.cidx = run_first;
            st_next.cend = run_last;
          end
        end
      end
      CMD_RUN: begin
        if (st_reg.code == CMD_CHECK_PAGE) begin
          // AND of every bit in the page
          rd_en[ridx[0]] = 1'b1;
          st_next.qacc = st_reg.qacc & (&word_lo);
        end else begin
          // buffer or erased value written word by word; buffer kept
          bk_we = 1'b1;
        end
        if (st_reg.cidx == st_reg.cend) begin
          st_next.cst = CMD_IDLE;
          st_next.status.command_done = 1'b1;
          if (st_reg.code == CMD_CHECK_PAGE) begin
            st_next.status.page_erase_check_result = st_reg.qacc & (&word_lo);
          end
        end else begin
          st_next.cidx = st_reg.cidx + 1'b1;
        end
      end
      default: st_next.cst = CMD_IDLE;
    endcase

    if (i_cmd_write) begin
      // key in top eight bits, valid code, controller free
      if (i_cmd_word.key != CMD_KEY || st_reg.cst != CMD_IDLE ||
          !(i_cmd_word.code inside {CMD_WRITE_PAGE, CMD_ERASE_PAGE, CMD_CLEAR_PB, CMD_ERASE_ALL,
            CMD_CHECK_PAGE, CMD_WRITE_USER, CMD_ERASE_USER, CMD_FAST_ON, CMD_FAST_OFF})) begin
        st_next.status.prog_error = 1'b1;
      end else begin
        st_next.cst = CMD_WAIT_IDLE;
        st_next.code = i_cmd_word.code;
        st_next.page_number_field = i_cmd_word.page;
        st_next.status.command_done = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '{ready: 1'b1, cst: CMD_IDLE, status: STATUS_RESET, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_hs_ready = st_reg.ready;
  assign o_hs_rdata = st_reg.rdata;
  assign o_status = st_reg.status;
  assign o_page_number = st_reg.page_number_field;
endmodule

/* testbench/nvm_controller_sva.sv */
`timescale 1ns/1ps
module nvm_controller_sva
  import nvm_pkg::*;
#(
  parameter int NUM_PAGES = 64,
  parameter logic [KEY_W-1:0] CMD_KEY = 8'h5A
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // High-speed bus
  input wire hs_req_t i_hs_req,
  input wire logic o_hs_ready,
  // Commands and status
  input wire logic i_cmd_write,
  input wire cmd_word_t i_cmd_word,
  input wire logic i_wait_state_select,
  input wire status_t o_status,
  input wire logic [PAGE_NUMBER_FIELD_W-1:0] o_page_number
);
  logic take_rd;
  logic take_wr;
  logic [ADDR_W-1:0] last_addr_reg;
  logic last_rd1_reg;

  // Only requests taken with no command pending or arriving have fixed timing
  assign take_rd = i_hs_req.valid && !i_hs_req.write && o_hs_ready && o_status.command_done && !i_cmd_write;
  assign take_wr = i_hs_req.valid && i_hs_req.write && o_hs_ready && o_status.command_done && !i_cmd_write;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      last_addr_reg <= '0;
      last_rd1_reg <= 1'b0;
    end else if (o_hs_ready) begin
      last_addr_reg <= i_hs_req.addr;
      last_rd1_reg <= take_rd && i_wait_state_select;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_write_stall;
    (!o_hs_ready) [*4] ##1 o_hs_ready;
  endsequence
  sequence s_first_stall;
    !o_hs_ready ##1 o_hs_ready;
  endsequence
  sequence s_fast_on_start;
    i_cmd_write && i_cmd_word.key == CMD_KEY && i_cmd_word.code == CMD_FAST_ON && o_status.command_done
    ##1 o_hs_ready && !i_hs_req.valid;
  endsequence

  a_buf_write_waits: assert property (take_wr |=> s_write_stall)
    else $error("buffer write wait count wrong");
  a_zero_wait_read: assert property (take_rd && !i_wait_state_select |=> o_hs_ready)
    else $error("zero-wait read stalled");
  a_first_beat_stall: assert property (take_rd && i_wait_state_select && !i_hs_req.seq |=> s_first_stall)
    else $error("first one-wait beat not stalled once");
  a_burst_beat_free: assert property (take_rd && i_wait_state_select && i_hs_req.seq && last_rd1_reg &&
      i_hs_req.addr == last_addr_reg + WORD_STEP |=> o_hs_ready)
    else $error("sequential beat stalled");
  a_page_number_load: assert property (take_wr ##1 (!i_cmd_write) [*5] |->
      o_page_number == $past(i_hs_req.addr[21:6], 5))
    else $error("page number not loaded from write address");
  a_fast_mode_on: assert property (s_fast_on_start |=> ##[0:2] o_status.fast_read_active)
    else $error("fast read mode not entered");
  a_bad_key_error: assert property (i_cmd_write && i_cmd_word.key != CMD_KEY |=> o_status.prog_error)
    else $error("bad key not flagged");
  a_read_stall_busy: assert property (i_hs_req.valid && !i_hs_req.write && o_hs_ready &&
      !o_status.command_done && $past(!o_status.command_done && o_hs_ready && !i_hs_req.valid)
      |=> !o_hs_ready || o_status.command_done)
    else $error("read not stalled during command");
endmodule

bind nvm_controller nvm_controller_sva #(
  .NUM_PAGES(NUM_PAGES),
  .CMD_KEY(CMD_KEY)
) u_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_hs_req(i_hs_req), .o_hs_ready(o_hs_ready),
  .i_cmd_write(i_cmd_write), .i_cmd_word(i_cmd_word), .i_wait_state_select(i_wait_state_select),
  .o_status(o_status), .o_page_number(o_page_number)
);

/* testbench/nvm_bus_master.sv */
`timescale 1ns/1ps
module nvm_bus_master
  import nvm_pkg::*;
(
  // Clock
  input wire logic i_clk,
  // Answer from the controller
  input wire logic i_hs_ready,
  input wire logic [DATA_W-1:0] i_hs_rdata,
  // Request to the controller
  output hs_req_t o_hs_req,
  output logic [DATA_W-1:0] o_hs_wdata
);
  logic [DATA_W-1:0] rd [8];
  int wt [8];
  logic timed_out;

  initial begin
    o_hs_req = '0;
    o_hs_wdata = '0;
    timed_out = 1'b0;
  end

  // full words, first beat address aligned; idle address and stale data are inverted
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input int n, input logic [DATA_W-1:0] wd);
    int k;
    int w;
    @(posedge i_clk);
    o_hs_req <= '{valid: 1'b1, seq: 1'b0, write: wr, addr: {a[ADDR_W-1:2], 2'h0}};
    for (k = 0; k <= n; k++) begin
      w = 0;
      @(posedge i_clk);
      while (i_hs_ready !== 1'b1 && w < 2000) begin
        w++;
        @(posedge i_clk);
      end
      if (w >= 2000) timed_out = 1'b1;
      if (k > 0) begin
        rd[k-1] = i_hs_rdata;
        wt[k-1] = w;
      end
      o_hs_wdata <= (k == 0) ? wd : ~wd;
      if (k < n - 1) o_hs_req <= '{valid: 1'b1, seq: 1'b1, write: wr, addr: a + ADDR_W'(4 * (k + 1))};
      else if (k == n - 1) o_hs_req <= '{valid: 1'b0, seq: 1'b0, write: 1'b0, addr: ~a};
    end
  endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import nvm_pkg::*;
  localparam logic [KEY_W-1:0] KEY = 8'h5A;
  logic i_clk;
  logic i_rst;
  hs_req_t i_hs_req;
  logic [DATA_W-1:0] i_hs_wdata;
  logic o_hs_ready;
  logic [DATA_W-1:0] o_hs_rdata;
  logic i_cmd_write;
  cmd_word_t i_cmd_word;
  logic i_status_read;
  logic i_wait_state_select;
  logic [NUM_REGIONS-1:0] i_region_lock;
  status_t o_status;
  logic [PAGE_NUMBER_FIELD_W-1:0] o_page_number;
  int mismatches;
  int check_count;
  int k;

  nvm_controller #(.NUM_PAGES(16), .CMD_KEY(KEY)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_hs_req(i_hs_req), .i_hs_wdata(i_hs_wdata),
    .o_hs_ready(o_hs_ready), .o_hs_rdata(o_hs_rdata), .i_cmd_write(i_cmd_write),
    .i_cmd_word(i_cmd_word), .i_status_read(i_status_read), .i_wait_state_select(i_wait_state_select),
    .i_region_lock(i_region_lock), .o_status(o_status), .o_page_number(o_page_number)
  );
  nvm_bus_master bm (
    .i_clk(i_clk), .i_hs_ready(o_hs_ready), .i_hs_rdata(o_hs_rdata), .o_hs_req(i_hs_req), .o_hs_wdata(i_hs_wdata)
  );

  always #2.5 i_clk = ~i_clk;

  task automatic report_and_stop();
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_val(nm, DATA_W'(e), DATA_W'(g));
  endtask
  task automatic chk_cnt(input string nm, input int e, input int g);
    chk_val(nm, DATA_W'(e), DATA_W'(g));
  endtask

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input int n, input logic [DATA_W-1:0] wd);
    bm.xfer(wr, a, n, wd);
    if (bm.timed_out) begin
      mismatches++;
      report_and_stop();
    end
  endtask

  task automatic cmd(input logic [CODE_W-1:0] cd, input logic [PAGE_NUMBER_FIELD_W-1:0] pg, input logic [KEY_W-1:0] ky,
                     input bit wait_done);
    int n;
    @(posedge i_clk);
    i_cmd_write <= 1'b1;
    i_cmd_word <= '{key: ky, page: pg, unused: 2'h0, code: cd};
    @(posedge i_clk);
    i_cmd_write <= 1'b0;
    for (n = 0; wait_done && n < 3000; n++) begin
      @(posedge i_clk);
      if (o_status.command_done === 1'b1) break;
    end
    if (n >= 3000) begin
      mismatches++;
      report_and_stop();
    end
    if (wait_done) @(posedge i_clk);
  endtask

  task automatic clr_status();
    @(posedge i_clk);
    i_status_read <= 1'b1;
    @(posedge i_clk);
    i_status_read <= 1'b0;
    @(posedge i_clk);
  endtask

  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_cmd_write = 1'b0;
    i_cmd_word = '0;
    i_status_read = 1'b0;
    i_wait_state_select = 1'b0;
    i_region_lock = '0;
    mismatches = 0;
    check_count = 0;
    repeat (8) @(posedge i_clk);
    chk_val("status", DATA_W'(STATUS_RESET), DATA_W'(o_status));
    chk_bit("ready", 1'b1, o_hs_ready);
    i_rst <= 1'b0;
    cmd(CMD_CLEAR_PB, 16'h0, KEY, 1'b1);
    bus(1'b1, 24'h0000D4, 1, 32'hF0F0_FF00);
    chk_cnt("write waits", 4, bm.wt[0]);
    chk_val("page number", 32'h3, DATA_W'(o_page_number));
    bus(1'b1, 24'h0003D4, 1, 32'h3C3C_0FFF);
    chk_val("page number", 32'hF, DATA_W'(o_page_number));
    cmd(CMD_WRITE_PAGE, 16'h3, KEY, 1'b1);
    bus(1'b0, 24'h0000D4, 1, '0);
    chk_val("page word", 32'h3030_0F00, bm.rd[0]);
    chk_cnt("read waits", 0, bm.wt[0]);
    cmd(CMD_WRITE_PAGE, 16'h4, KEY, 1'b0);
    bus(1'b0, 24'h000114, 1, '0);
    chk_val("busy read", 32'h3030_0F00, bm.rd[0]);
    chk_bit("busy stall", 1'b1, bm.wt[0] > 8);
    cmd(CMD_CHECK_PAGE, 16'h3, KEY, 1'b1);
    chk_bit("check used", 1'b0, o_status.page_erase_check_result);
    cmd(CMD_CLEAR_PB, 16'h0, KEY, 1'b1);
    cmd(CMD_WRITE_PAGE, 16'h5, KEY, 1'b1);
    cmd(CMD_CHECK_PAGE, 16'h5, KEY, 1'b1);
    chk_bit("check clear", 1'b1, o_status.page_erase_check_result);
    bus(1'b0, 24'h000140, 1, '0);
    chk_val("cleared word", ERASED_WORD, bm.rd[0]);
    i_wait_state_select <= 1'b1;
    bus(1'b0, 24'h0000D0, 4, '0);
    for (k = 0; k < 4; k++) begin
      chk_cnt("burst waits", (k == 0) ? 1 : 0, bm.wt[k]);
      chk_val("burst word", (k == 1) ? 32'h3030_0F00 : ERASED_WORD, bm.rd[k]);
    end
    bus(1'b0, 24'h0000D4, 1, '0);
    chk_cnt("single waits", 1, bm.wt[0]);
    i_wait_state_select <= 1'b0;
    cmd(CMD_ERASE_PAGE, 16'h3, KEY, 1'b1);
    cmd(CMD_CHECK_PAGE, 16'h3, KEY, 1'b1);
    chk_bit("erased page", 1'b1, o_status.page_erase_check_result);
    cmd(CMD_FAST_ON, 16'h0, KEY, 1'b1);
    chk_bit("fast on", 1'b1, o_status.fast_read_active);
    cmd(CMD_FAST_OFF, 16'h0, KEY, 1'b1);
    chk_bit("fast off", 1'b0, o_status.fast_read_active);
    cmd(CMD_FAST_ON, 16'h0, 8'hA5, 1'b1);
    chk_bit("bad key", 1'b1, o_status.prog_error);
    chk_bit("no effect", 1'b0, o_status.fast_read_active);
    clr_status();
    chk_bit("error cleared", 1'b0, o_status.prog_error);
    i_region_lock <= 16'h0040;
    cmd(CMD_WRITE_PAGE, 16'h6, KEY, 1'b1);
    chk_bit("lock error", 1'b1, o_status.lock_error);
    clr_status();
    i_region_lock <= '0;
    bus(1'b1, 24'h000008, 1, 32'h1234_5678);
    cmd(CMD_WRITE_USER, 16'h0, KEY, 1'b1);
    cmd(CMD_ERASE_ALL, 16'h0, KEY, 1'b1);
    bus(1'b0, USER_PAGE_BASE + 24'h000008, 1, '0);
    chk_val("user word", 32'h1234_5678, bm.rd[0]);
    bus(1'b0, 24'h000114, 1, '0);
    chk_val("erased array", ERASED_WORD, bm.rd[0]);
    cmd(CMD_ERASE_USER, 16'h0, KEY, 1'b1);
    bus(1'b0, USER_PAGE_BASE + 24'h000008, 1, '0);
    chk_val("user erased", ERASED_WORD, bm.rd[0]);
    report_and_stop();
  end
endmodule
